// [design/qad_addr_decoder.sv]
// Purpose: latch the target address from three five-level pads and
//          match the first byte after START; gate the LED outputs
// Assumes: bus events come decoded and synchronous to clk_i
// Notes: pad sense turns off once the address is latched
`timescale 1ns/10ps
`include "qad_consts.svh"
module qad_addr_decoder #(
   parameter int SETTLE_CYC = `QAD_SETTLE_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // resets other than power-up
   input wire logic pin_reset_n_i,
   input wire logic soft_reset_i,
   // pads
   input wire qad_pkg::qad_pads_t pad_level_i,
   output logic pad_sense_en_o,
   // bus events
   input wire qad_pkg::qad_bus_t bus_i,
   // output enable and leds
   input wire logic out_en_n_i,
   input wire logic [`QAD_LED_W-1:0] led_req_i,
   output logic [`QAD_LED_W-1:0] led_on_o,
   // status
   output logic [`QAD_ADDR_W-1:0] target_addr_o,
   output logic addr_valid_o,
   output logic in_reset_o,
   output logic ack_o,
   output logic read_o,
   output logic selected_o
);
   // the settle counter cannot reach counts beyond its width
   if (SETTLE_CYC < 1 || SETTLE_CYC > (1 << `QAD_CNT_W) - 1) begin : g_bad
      $error("SETTLE_CYC out of range");
   end

   // ----------------------------------------------------------------
   // pad classification
   // ----------------------------------------------------------------
   qad_pkg::qad_level_t st_u, st_f, st_t;
   qad_pad_class u_cls_units (.level_i(pad_level_i.addr_pad_units),
      .state_o(st_u));
   qad_pad_class u_cls_fives (.level_i(pad_level_i.addr_pad_fives),
      .state_o(st_f));
   qad_pad_class u_cls_tf (.level_i(pad_level_i.addr_pad_twentyfives),
      .state_o(st_t));

   wire logic [6:0] val_u = {4'h0, st_u};
   wire logic [6:0] val_f = {4'h0, st_f};
   wire logic [6:0] val_t = {4'h0, st_t};
   wire logic [6:0] calc_addr = 7'(val_t * `QAD_WEIGHT_TWENTYFIVES
      + val_f * `QAD_WEIGHT_FIVES + val_u + `QAD_ADDR_BASE);

   // ----------------------------------------------------------------
   // reset and latch sequence
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {QAD_HOLD, QAD_SETTLE, QAD_LATCHED} qad_st_t;
   qad_st_t state, next_state;
   logic [`QAD_CNT_W-1:0] cnt, next_cnt;
   logic power_done;
   wire logic any_reset = !pin_reset_n_i || soft_reset_i;
   // after power-up latch, pads stay off; the address holds across pin and soft resets
   wire logic sense_allowed = !power_done;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         QAD_HOLD: begin
            if (!any_reset) begin
               next_state = sense_allowed ? QAD_SETTLE : QAD_LATCHED;
               next_cnt = '0;
            end
         end
         QAD_SETTLE: begin
            if (any_reset) begin
               next_state = QAD_HOLD;
            end else if (cnt == `QAD_CNT_W'(SETTLE_CYC - 1)) begin
               next_state = QAD_LATCHED;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         QAD_LATCHED: begin
            if (any_reset) begin
               next_state = QAD_HOLD;
            end
         end
      endcase
   end

   wire logic latch_now = (state == QAD_SETTLE) && !any_reset
      && (cnt == `QAD_CNT_W'(SETTLE_CYC - 1));

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= QAD_HOLD;
         cnt <= '0;
         power_done <= 1'b0;
         target_addr_o <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         if (latch_now) begin
            power_done <= 1'b1;
            target_addr_o <= calc_addr;
         end
      end
   end

   assign pad_sense_en_o = (state == QAD_SETTLE);
   assign addr_valid_o = power_done;
   assign in_reset_o = (state != QAD_LATCHED);

   // ----------------------------------------------------------------
   // address byte match
   // ----------------------------------------------------------------
   logic [7:0] shreg;
   logic [2:0] bitn;
   logic in_addr, next_in_addr;
   logic sel;
   wire logic active = (state == QAD_LATCHED);
   wire logic byte_done = bus_i.bit_valid && in_addr
      && (bitn == `QAD_BIT_LAST);
   wire logic [7:0] full_byte = {shreg[6:0], bus_i.bit_val};
   wire logic hit = (full_byte[7:1] == target_addr_o);

   always_comb begin
      next_in_addr = in_addr;
      if (bus_i.start) begin
         next_in_addr = active;
      end else if (byte_done || bus_i.stop) begin
         next_in_addr = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shreg <= '0;
         bitn <= '0;
         in_addr <= 1'b0;
         sel <= 1'b0;
         ack_o <= 1'b0;
         read_o <= 1'b0;
      end else begin
         in_addr <= next_in_addr;
         ack_o <= byte_done && hit && active && !any_reset;
         if (bus_i.start) begin
            bitn <= '0;
            sel <= 1'b0;
         end else if (bus_i.stop || !active) begin
            sel <= 1'b0;
         end else if (bus_i.bit_valid && in_addr) begin
            shreg <= full_byte;
            bitn <= bitn + 1'b1;
            if (byte_done) begin
               sel <= hit;
               read_o <= full_byte[0];
            end
         end
      end
   end
   assign selected_o = sel;

   // ----------------------------------------------------------------
   // output enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         led_on_o <= '0;
      end else begin
         led_on_o <= (out_en_n_i || !active) ? '0 : led_req_i;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_settle_end;
      (state == QAD_SETTLE) && latch_now;
   endsequence

   chk_addr_formula: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) s_settle_end |=> target_addr_o == $past(calc_addr))
      else $error("latched address wrong");
   chk_sense_off: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) power_done |-> !pad_sense_en_o)
      else $error("pads sensed after latch");
   chk_addr_stable: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) power_done |=> $stable(target_addr_o))
      else $error("address changed after latch");
   chk_addr_range: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) power_done |-> (target_addr_o >= `QAD_ADDR_BASE
      && target_addr_o <= `QAD_ADDR_MAX))
      else $error("address out of range");
   chk_oe_off: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) out_en_n_i |=> led_on_o == '0)
      else $error("led on while disabled");
   chk_reset_hold: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) !pin_reset_n_i |=> in_reset_o && !ack_o)
      else $error("active during reset");
   chk_ack_match: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) ack_o |-> $past(full_byte[7:1]) == target_addr_o)
      else $error("ack without match");
   chk_sel_clear: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) bus_i.start |=> !selected_o)
      else $error("selection kept over START");
   chk_read_flag: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) (byte_done && hit && active) |=>
      read_o == $past(bus_i.bit_val))
      else $error("read flag not bit 0");
   chk_settle_len: assert property (@(posedge clk_i) disable iff
      (!reset_n_i) $rose(pad_sense_en_o) && !any_reset
      |-> ##[1:63] !pad_sense_en_o)
      else $error("settle too long");
endmodule

// [design/qad_consts.svh]
// Purpose: named constants for the quinary target address decoder
// Assumes: 40 MHz clock
// Notes: definitions only
`ifndef QAD_CONSTS_SVH
`define QAD_CONSTS_SVH
`define QAD_ADDR_W 7
`define QAD_PAD_W 3
`define QAD_ADDR_BASE 7'h01
`define QAD_WEIGHT_FIVES 7'h05
`define QAD_WEIGHT_TWENTYFIVES 7'h19
`define QAD_PAD_MAX 3'h4
`define QAD_ADDR_MAX 7'h7d
`define QAD_SETTLE_NS 1000
`define QAD_CLK_NS 25
`define QAD_SETTLE_CYC ((`QAD_SETTLE_NS + `QAD_CLK_NS - 1) / `QAD_CLK_NS)
`define QAD_CNT_W 6
`define QAD_LED_W 16
`define QAD_BIT_LAST 3'h7
`endif

// [design/qad_pkg.sv]
// Purpose: types for the quinary target address decoder
// Assumes: nothing
// Notes: pad levels encoded 0..4
package qad_pkg;
   typedef enum logic [2:0] {
      QAD_GROUND = 3'h0,
      QAD_RESISTOR_PULLDOWN_STATE = 3'h1,
      QAD_OPEN_PAD_STATE = 3'h2,
      QAD_RESISTOR_PULLUP_STATE = 3'h3,
      QAD_SUPPLY = 3'h4
   } qad_level_t;
   typedef struct packed {
      logic [2:0] addr_pad_twentyfives;
      logic [2:0] addr_pad_fives;
      logic [2:0] addr_pad_units;
   } qad_pads_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic bit_valid;
      logic bit_val;
   } qad_bus_t;
endpackage

// [design/qad_pad_class.sv]
// Purpose: classify one five-level pad into its state value
// Assumes: analog sense gives a 3-bit level code 0..4
// Notes: codes above 4 read as supply
`timescale 1ns/10ps
`include "qad_consts.svh"
module qad_pad_class (
   // sensed level
   input wire logic [2:0] level_i,
   // resolved state
   output qad_pkg::qad_level_t state_o
);
   // out-of-range codes clamp high rather than alias to a low address
   wire logic over = (level_i > `QAD_PAD_MAX);
   assign state_o = over ? qad_pkg::QAD_SUPPLY
                         : qad_pkg::qad_level_t'(level_i);
endmodule

// [tb/qad_bus_ctl.sv]
// Purpose: bus controller model sending decoded address bytes
// Assumes: events are one-cycle pulses launched at the falling edge
// Notes: idle data after a byte shows the inverse of the last bit; send_stop keeps that value
`timescale 1ns/10ps
module qad_bus_ctl (
   // clock and target answer
   input wire logic clk_i,
   input wire logic ack_i,
   // decoded bus events
   output qad_pkg::qad_bus_t bus_o
);
   initial begin
      bus_o = '0;
   end
   // the answer is taken in the slot after the eighth bit, while it stands
   task automatic send(input logic [7:0] b, output logic acked);
      @(negedge clk_i);
      bus_o = '{start: 1'b1, default: 1'b0};
      for (int i = 7; i >= 0; i--) begin
         @(negedge clk_i);
         bus_o = '{bit_valid: 1'b1, bit_val: b[i], default: 1'b0};
      end
      @(negedge clk_i);
      bus_o = '{bit_val: ~b[0], default: 1'b0};
      acked = ack_i;
   endtask
   task automatic send_stop;
      @(negedge clk_i);
      bus_o = '{stop: 1'b1, bit_val: bus_o.bit_val, default: 1'b0};
      @(negedge clk_i);
      bus_o = '{bit_val: bus_o.bit_val, default: 1'b0};
   endtask
endmodule

// [tb/quinary_target_address_decoder_tb_top.sv]
// Purpose: self-checking bench for the address decoder
// Assumes: short settle count to keep the run brief
// Notes: random pads with both end corners
`timescale 1ns/10ps
`include "qad_consts.svh"
module quinary_target_address_decoder_tb_top;
   logic clk_i = 0, reset_n_i, pin_reset_n_i = 1, soft_reset_i = 0;
   logic out_en_n_i = 1, got, sensed;
   logic [15:0] led_req_i = 16'h0000, led_on_o;
   logic [6:0] target_addr_o, e;
   logic pad_sense_en_o, addr_valid_o, in_reset_o, ack_o, read_o;
   logic selected_o;
   qad_pkg::qad_pads_t pad_level_i = '0, p;
   qad_pkg::qad_bus_t bus_i;
   int miscompares = 0, checked = 0;
   qad_addr_decoder #(.SETTLE_CYC(2)) dut_u (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .pin_reset_n_i(pin_reset_n_i),
      .soft_reset_i(soft_reset_i), .pad_level_i(pad_level_i),
      .pad_sense_en_o(pad_sense_en_o), .bus_i(bus_i),
      .out_en_n_i(out_en_n_i), .led_req_i(led_req_i),
      .led_on_o(led_on_o), .target_addr_o(target_addr_o),
      .addr_valid_o(addr_valid_o), .in_reset_o(in_reset_o),
      .ack_o(ack_o), .read_o(read_o), .selected_o(selected_o));
   qad_bus_ctl bus_u (.clk_i(clk_i), .ack_i(ack_o), .bus_o(bus_i));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   // -------------------------------------------
   // helpers
   // -------------------------------------------
   function automatic logic [6:0] exp_addr(qad_pkg::qad_pads_t q);
      return 7'(25 * q.addr_pad_twentyfives + 5 * q.addr_pad_fives
         + q.addr_pad_units + 1);
   endfunction
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // bounded wait for the latched state
   task automatic wait_run;
      sensed = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk_i);
         if (pad_sense_en_o === 1'b1) sensed = 1'b1;
         if (in_reset_o === 1'b0) return;
      end
      miscompares++;
      $display("CHECK FAILED %0t wait for run state", $time);
      close_out();
   endtask
   task automatic send_chk(input logic [7:0] b, input logic want);
      bus_u.send(b, got);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_i);
         if (ack_o === 1'b1) got = 1'b1;
      end
      chk(got === want, "ack");
      chk(selected_o === want, "selected");
   endtask
   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      void'($urandom(32'he9d7));
      // an edge from unknown to low starts the asynchronous reset at once
      reset_n_i = 1'b0;
      for (int t = 0; t < 8; t++) begin
         p = {3'(t == 1 ? 4 : $urandom_range(4)),
            3'(t == 1 ? 4 : $urandom_range(4)),
            3'(t == 1 ? 4 : $urandom_range(4))};
         if (t == 0) p = '0;
         e = exp_addr(p);
         @(negedge clk_i);
         reset_n_i = 0;
         pad_level_i = p;
         repeat (20) @(negedge clk_i);
         chk(in_reset_o === 1'b1, "reset state");
         reset_n_i = 1;
         wait_run();
         chk(target_addr_o === e, "address");
         chk(sensed === 1'b1, "pads sensed");
         chk(addr_valid_o === 1'b1, "valid");
         chk(pad_sense_en_o === 1'b0, "sense off");
         send_chk({e, 1'b1}, 1'b1);
         chk(read_o === 1'b1, "read flag");
         bus_u.send_stop();
         chk(selected_o === 1'b0, "stop clears");
         send_chk({e + 7'h01, 1'b0}, 1'b0);
         led_req_i = 16'($urandom);
         out_en_n_i = 0;
         repeat (2) @(negedge clk_i);
         chk(led_on_o === led_req_i, "leds on");
         out_en_n_i = 1;
         repeat (2) @(negedge clk_i);
         chk(led_on_o === 16'h0000, "leds off");
         pad_level_i = ~p;
         if (t[0]) pin_reset_n_i = 0;
         else soft_reset_i = 1;
         repeat (3) @(negedge clk_i);
         chk(in_reset_o === 1'b1, "held in reset");
         pin_reset_n_i = 1;
         soft_reset_i = 0;
         wait_run();
         chk(target_addr_o === e, "address kept");
         chk(sensed === 1'b0, "no resample");
         send_chk({e, 1'b0}, 1'b1);
         chk(read_o === 1'b0, "write flag");
         $display("test %0d done", t);
      end
      close_out();
   end
endmodule
